// File: eeprom_port_pkg.sv
// Package of constants for the serial configuration memory port.
`default_nettype none
package eeprom_port_pkg;
  // Serial clock half period in core clock cycles.
  localparam int unsigned HALF_PERIOD_CYCLES = 4;
  // Opcode, address and data widths of one serial command.
  localparam int unsigned OPCODE_BITS = 3;
  localparam int unsigned ADDR_BITS   = 6;
  localparam int unsigned DATA_BITS   = 16;
  localparam int unsigned FRAME_BITS  = OPCODE_BITS + ADDR_BITS + DATA_BITS;
  // Opcodes of the serial command set.
  localparam logic [2:0] OP_READ  = 3'h6;
  localparam logic [2:0] OP_WRITE = 3'h5;
  // Number of words loaded automatically after reset.
  localparam int unsigned AUTOLOAD_WORDS = 12;
  // Cycles after reset release for the strap to settle; the synchroniser lag is added before it is caught.
  localparam int unsigned STRAP_SETTLE_CYCLES = 4;
  // Core cycles for a pin level to pass the three-stage input synchroniser.
  localparam int unsigned SYNC_LATENCY_CYCLES = 4;
endpackage
`default_nettype wire

// File: pin_sync.sv
// Three-stage synchroniser with a two-agree change filter.
`default_nettype none
module pin_sync
  import eeprom_port_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // The first stage feeds only the second, to contain metastability.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_q  <= RESET_LEVEL;
      s2_q  <= RESET_LEVEL;
      s3_q  <= RESET_LEVEL;
      level <= RESET_LEVEL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level <= s2_q;
      end
    end
  end
endmodule
`default_nettype wire

// File: serial_config_eeprom_port.sv
// Serial configuration memory port with shared boot ROM pins and autoload.
// Notes on behaviour
// RL1: Select asserted for every access, otherwise low.
// RL2: Serial clock driven on address bit four pin.
// RL3: Opcode, address, write data shifted out serially.
// RL4: Read data sampled from shared data bit four.
// RL5: Low strap at power-on skips configuration autoload.
// RL6: Strap pin becomes bidirectional ROM data afterwards.
// RL7: Memory access never overlaps a boot ROM access.
`default_nettype none
module serial_config_eeprom_port
  import eeprom_port_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = HALF_PERIOD_CYCLES,
  parameter int unsigned LOAD_WORDS  = AUTOLOAD_WORDS
) (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 cmd_valid,
  input  wire logic                 cmd_write,
  input  wire logic [ADDR_BITS-1:0] cmd_addr,
  input  wire logic [DATA_BITS-1:0] cmd_wdata,
  output logic                      cmd_ready,
  output logic                      rsp_valid,
  output logic [DATA_BITS-1:0]      rsp_rdata,
  output logic                      load_valid,
  output logic [ADDR_BITS-1:0]      load_addr,
  output logic [DATA_BITS-1:0]      load_data,
  output logic                      load_done,
  output logic                      load_skipped,
  input  wire logic                 rom_req,
  output logic                      rom_grant,
  input  wire logic                 rom_addr4,
  input  wire logic                 rom_addr3,
  input  wire logic                 rom_data1_out,
  input  wire logic                 rom_data1_drive,
  output logic                      rom_data1_in,
  output logic                      rom_data4_in,
  output logic                      serial_memory_select,
  output logic                      boot_rom_addr_bit4,
  output logic                      boot_rom_addr_bit3,
  input  wire logic                 boot_rom_data_bit4,
  input  wire logic                 boot_rom_data_bit1_in,
  output logic                      boot_rom_data_bit1_out,
  output logic                      boot_rom_data_bit1_oe_n
);
  typedef enum logic [2:0] {
    STRAP_WAIT, IDLE, SHIFT, FINISH, ROM
  } state_type;

  localparam int unsigned CNT_W = $clog2(FRAME_BITS + 1);
  localparam int unsigned HC_W  = $clog2(HALF_CYCLES + 1);
  localparam int unsigned ST_W  = $clog2(STRAP_SETTLE_CYCLES + SYNC_LATENCY_CYCLES + 1);

  state_type                state_q;
  logic [FRAME_BITS-1:0]    shift_q;
  logic [DATA_BITS-1:0]     rdata_q;
  logic [CNT_W-1:0]         bits_q;
  logic [HC_W-1:0]          half_q;
  logic                     sclk_q;
  logic                     is_write_q;
  logic                     auto_q;
  logic [ADDR_BITS-1:0]     auto_addr_q;
  logic [ST_W-1:0]          settle_q;
  logic                     ret_line;
  logic                     strap_line;
  logic                     tick;

  // Pin inputs come from outside the clock domain.
  pin_sync #(.RESET_LEVEL(1'b1)) u_sync_ret (
    .clock (clock),
    .rst_n (rst_n),
    .pin   (boot_rom_data_bit4),
    .level (ret_line)
  );
  pin_sync #(.RESET_LEVEL(1'b1)) u_sync_strap (
    .clock (clock),
    .rst_n (rst_n),
    .pin   (boot_rom_data_bit1_in),
    .level (strap_line)
  );

  // Builds one serial frame: opcode, then address, then data.
  function automatic logic [FRAME_BITS-1:0] frame(input logic wr,
                                                  input logic [ADDR_BITS-1:0] a,
                                                  input logic [DATA_BITS-1:0] d);
    frame = {wr ? OP_WRITE : OP_READ, a, d};
  endfunction

  // Serial clock pacing; a tick marks each half period.
  assign tick = (half_q == HC_W'(HALF_CYCLES - 1));
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      half_q <= '0;
    end else if (state_q != SHIFT || tick) begin
      half_q <= '0;
    end else begin
      half_q <= half_q + HC_W'(1);
    end
  end

  // Main sequencer; the strap is caught a few cycles after reset release.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= STRAP_WAIT;
      settle_q     <= '0;
      auto_q       <= 1'b0;
      auto_addr_q  <= '0;
      load_skipped <= 1'b0;
      load_done    <= 1'b0;
      shift_q      <= '0;
      bits_q       <= '0;
      sclk_q       <= 1'b0;
      is_write_q   <= 1'b0;
      rdata_q      <= '0;
    end else begin
      unique case (state_q)
        STRAP_WAIT: begin
          settle_q <= settle_q + ST_W'(1);
          // The synchroniser lag is waited out too, else a low strap still reads high.
          if (settle_q == ST_W'(STRAP_SETTLE_CYCLES + SYNC_LATENCY_CYCLES - 1)) begin
            if (!strap_line) begin
              load_skipped <= 1'b1; // RL5
              load_done    <= 1'b1;
              state_q      <= IDLE;
            end else begin
              auto_q     <= 1'b1; // RL5
              shift_q    <= frame(1'b0, '0, '0);
              is_write_q <= 1'b0;
              bits_q     <= '0;
              state_q    <= SHIFT;
            end
          end
        end
        IDLE: begin
          // Autoload and host commands take priority over the ROM while pending.
          if (cmd_valid && load_done) begin
            shift_q    <= frame(cmd_write, cmd_addr, cmd_wdata); // RL3
            is_write_q <= cmd_write;
            bits_q     <= '0;
            state_q    <= SHIFT;
          end else if (rom_req && load_done) begin
            state_q <= ROM; // RL7
          end
        end
        SHIFT: begin
          if (tick) begin
            sclk_q <= ~sclk_q; // RL2
            if (sclk_q) begin
              // Falling edge: take the returned bit, then present the next one.
              // The bit is taken late in its period because the synchroniser lags the pin.
              if (!is_write_q && bits_q >= CNT_W'(OPCODE_BITS + ADDR_BITS)) begin
                rdata_q <= {rdata_q[DATA_BITS-2:0], ret_line}; // RL4
              end
              shift_q <= {shift_q[FRAME_BITS-2:0], 1'b0}; // RL3
              bits_q  <= bits_q + CNT_W'(1);
              if (bits_q == CNT_W'(FRAME_BITS - 1)) begin
                state_q <= FINISH;
              end
            end
          end
        end
        FINISH: begin
          state_q <= IDLE;
          if (auto_q) begin
            if (auto_addr_q == ADDR_BITS'(LOAD_WORDS - 1)) begin
              auto_q    <= 1'b0;
              load_done <= 1'b1;
            end else begin
              auto_addr_q <= auto_addr_q + ADDR_BITS'(1);
              shift_q     <= frame(1'b0, auto_addr_q + ADDR_BITS'(1), '0);
              bits_q      <= '0;
              state_q     <= SHIFT;
            end
          end
        end
        ROM: begin
          if (!rom_req) begin
            state_q <= IDLE;
          end
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  // Registered outputs; pins carry the ROM bus only in the ROM state, the address pins carry serial clock and data in SHIFT, and sit low otherwise.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      serial_memory_select    <= 1'b0;
      boot_rom_addr_bit4      <= 1'b0;
      boot_rom_addr_bit3      <= 1'b0;
      boot_rom_data_bit1_out  <= 1'b0;
      boot_rom_data_bit1_oe_n <= 1'b1;
      rom_grant               <= 1'b0;
      cmd_ready               <= 1'b0;
      rsp_valid               <= 1'b0;
      rsp_rdata               <= '0;
      load_valid              <= 1'b0;
      load_addr               <= '0;
      load_data               <= '0;
      rom_data1_in            <= 1'b1;
      rom_data4_in            <= 1'b1;
    end else begin
      serial_memory_select <= (state_q == SHIFT); // RL1
      rom_grant            <= (state_q == ROM); // RL7
      if (state_q == SHIFT) begin
        boot_rom_addr_bit4 <= sclk_q; // RL2
        boot_rom_addr_bit3 <= shift_q[FRAME_BITS-1]; // RL3
      end else begin
        boot_rom_addr_bit4 <= (state_q == ROM) ? rom_addr4 : 1'b0;
        boot_rom_addr_bit3 <= (state_q == ROM) ? rom_addr3 : 1'b0;
      end
      // Strap pin stays undriven until sampled, then serves as ROM data.
      boot_rom_data_bit1_out  <= rom_data1_out; // RL6
      boot_rom_data_bit1_oe_n <= !(state_q == ROM && rom_data1_drive); // RL6
      rom_data1_in            <= strap_line;
      rom_data4_in            <= ret_line;
      cmd_ready  <= (state_q == IDLE) && load_done && !cmd_valid;
      rsp_valid  <= (state_q == FINISH) && !auto_q;
      load_valid <= (state_q == FINISH) && auto_q && !is_write_q;
      if (state_q == FINISH) begin
        rsp_rdata <= rdata_q;
        load_data <= rdata_q;
        load_addr <= auto_addr_q;
      end
    end
  end

  // The select never coincides with a granted ROM cycle.
  property p_no_overlap;
    @(posedge clock) disable iff (!rst_n) !(serial_memory_select && rom_grant);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("select overlaps ROM"); // RL7

  // Select follows a shifting sequencer one cycle later.
  property p_select;
    @(posedge clock) disable iff (!rst_n) (state_q == SHIFT) |=> serial_memory_select;
  endproperty
  a_select: assert property (p_select) else $error("select not asserted"); // RL1

  // Select drops when the sequencer is idle.
  property p_select_off;
    @(posedge clock) disable iff (!rst_n) (state_q == IDLE) |=> !serial_memory_select;
  endproperty
  a_select_off: assert property (p_select_off) else $error("select left high"); // RL1

  // Serial clock pin idles low without select or ROM grant.
  property p_clk_idle;
    @(posedge clock) disable iff (!rst_n)
      (!serial_memory_select && !rom_grant) |-> !boot_rom_addr_bit4;
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("clock active idle"); // RL2

  // Out line carries the frame head during shifting.
  property p_out_bit;
    @(posedge clock) disable iff (!rst_n)
      (state_q == SHIFT) |=> (boot_rom_addr_bit3 == $past(shift_q[FRAME_BITS-1]));
  endproperty
  a_out_bit: assert property (p_out_bit) else $error("out bit wrong"); // RL3

  // A low strap marks the load skipped and done together.
  property p_skip;
    @(posedge clock) disable iff (!rst_n) load_skipped |-> load_done && !auto_q;
  endproperty
  a_skip: assert property (p_skip) else $error("skip inconsistent"); // RL5

  // Strap pin is not driven before it is sampled.
  property p_strap_free;
    @(posedge clock) disable iff (!rst_n)
      (state_q == STRAP_WAIT) |=> boot_rom_data_bit1_oe_n;
  endproperty
  a_strap_free: assert property (p_strap_free) else $error("strap driven early"); // RL6

  // Read data only moves while a frame is shifting.
  property p_read_sample;
    @(posedge clock) disable iff (!rst_n)
      (state_q != SHIFT) |=> $stable(rdata_q);
  endproperty
  a_read_sample: assert property (p_read_sample) else $error("read data moved"); // RL4
endmodule
`default_nettype wire

// File: serial_memory_model.sv
// Behavioural model of the serial configuration memory on the far side of the port.
`default_nettype none
module serial_memory_model
  import eeprom_port_pkg::*;
(
  input  wire logic sel,
  input  wire logic sclk,
  input  wire logic din,
  output logic      dout
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [64];
  logic [8:0]  hdr;
  logic [15:0] sh;
  int          cnt;
  // Contents follow a fixed pattern so that the bench can predict every word.
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = {4'ha, i[5:0], i[5:0]};
    dout = 1'b1;
    cnt  = 0;
  end
  // Each new select starts a fresh frame.
  always @(posedge sel) cnt = 0;
  // Opcode and address come first, then data; a write lands only once the last bit is in.
  always @(posedge sclk) if (sel) begin
    if (cnt < 9) hdr = {hdr[7:0], din};
    else sh = {sh[14:0], din};
    cnt++;
    if (cnt == 25 && hdr[8:6] == OP_WRITE) mem[hdr[5:0]] = sh;
  end
  // Read bits change on the falling edge; when released, the pull-up wins.
  always @(negedge sclk or negedge sel) begin
    if (sel && cnt >= 9 && cnt < 25 && hdr[8:6] == OP_READ) dout = mem[hdr[5:0]][24 - cnt];
    else dout = 1'b1;
  end
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the serial configuration memory port.
`default_nettype none
module tb_top
  import eeprom_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rst_n, cmd_valid, cmd_write, rsp_valid, load_valid, load_done, load_skipped;
  logic rom_req, rom_grant, rom_addr4, rom_addr3, rom_data1_out, rom_data1_drive, rom_data1_in;
  logic select, sclk, sout, ret, pin1, d1_out, d1_oe_n, strap;
  logic cmd_ready, rom_data4_in;
  logic [5:0]  cmd_addr, load_addr;
  logic [15:0] cmd_wdata, rsp_rdata, load_data, rd;
  logic [24:0] frame;
  int          errors, checks, loads, nbits;
  // The strap pin is the device's own value while it drives, else the board level.
  assign pin1 = (d1_oe_n === 1'b0) ? d1_out : strap;
  serial_config_eeprom_port dut (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .load_valid(load_valid),
    .load_addr(load_addr), .load_data(load_data), .load_done(load_done),
    .load_skipped(load_skipped), .rom_req(rom_req), .rom_grant(rom_grant),
    .rom_addr4(rom_addr4), .rom_addr3(rom_addr3), .rom_data1_out(rom_data1_out),
    .rom_data1_drive(rom_data1_drive), .rom_data1_in(rom_data1_in), .rom_data4_in(rom_data4_in),
    .serial_memory_select(select), .boot_rom_addr_bit4(sclk), .boot_rom_addr_bit3(sout),
    .boot_rom_data_bit4(ret), .boot_rom_data_bit1_in(pin1),
    .boot_rom_data_bit1_out(d1_out), .boot_rom_data_bit1_oe_n(d1_oe_n));
  serial_memory_model mem_model (.sel(select), .sclk(sclk), .din(sout), .dout(ret));
  // Clock of 50 ns period.
  initial clock = 1'b0;
  always #25 clock = ~clock;
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Ends 5 ns after an edge, which is both the drive point and a settled sample point.
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask
  // The serial line is watched at every rising serial clock inside a frame.
  always @(posedge sclk) if (select === 1'b1) begin
    frame = {frame[23:0], sout};
    nbits++;
  end
  // Every autoloaded word must come in address order with the stored contents.
  // Taken at the falling edge, where the one-cycle pulse has settled.
  always @(negedge clock) if (load_valid === 1'b1) begin
    check({10'h0, load_addr}, loads[15:0], "load addr");
    check(load_data, {4'ha, loads[5:0], loads[5:0]}, "load data");
    loads++;
  end
  // Shared pins may never be handed to the ROM side during a serial access.
  always @(posedge clock) if (rst_n === 1'b1 && select === 1'b1) check(rom_grant, 0, "grant");
  task automatic do_reset(input logic s);
    rst_n = 1'b0;
    strap = s;
    loads = 0;
    tick(4);
    rst_n = 1'b1;
    for (int i = 0; i < 6000 && load_done !== 1'b1; i++) tick(1);
    tick(1);
    check(load_done, 1, "load done");
  endtask
  // Request is held until the select shows acceptance, then dropped.
  task automatic do_cmd(input logic w, input logic [5:0] a, input logic [15:0] d);
    nbits = 0;
    check(cmd_ready, 1, "ready idle");
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    for (int i = 0; i < 60 && select !== 1'b1; i++) tick(1);
    cmd_valid = 1'b0;
    for (int i = 0; i < 400 && rsp_valid !== 1'b1; i++) tick(1);
    check(rsp_valid, 1, "response");
    rd = rsp_rdata;
    check(nbits[15:0], FRAME_BITS, "frame length");
    tick(1);
    check(select, 0, "select idle");
  endtask
  task automatic t_autoload();
    do_reset(1'b1);
    check(loads[15:0], AUTOLOAD_WORDS, "load count");
    check(load_skipped, 0, "not skipped");
  endtask
  task automatic t_write_read();
    do_cmd(1'b1, 6'h2a, 16'hc35a);
    check(frame[24:16], {OP_WRITE, 6'h2a}, "write header");
    check(frame[15:0], 16'hc35a, "write data");
    do_cmd(1'b0, 6'h2a, 16'h0000);
    check(frame[24:16], {OP_READ, 6'h2a}, "read header");
    check(rd, 16'hc35a, "read back");
    do_cmd(1'b0, 6'h3f, 16'hffff);
    check(rd, {4'ha, 6'h3f, 6'h3f}, "read top");
  endtask
  // ROM request arrives mid-frame; it must wait, and commands wait while ROM owns pins.
  task automatic t_rom_share();
    rom_addr4 = 1'b1;
    rom_addr3 = 1'b0;
    fork
      do_cmd(1'b0, 6'h05, 16'h0000);
      begin
        tick(30);
        rom_req = 1'b1;
      end
    join
    check(rd, {4'ha, 6'h05, 6'h05}, "read under contention");
    for (int i = 0; i < 20 && rom_grant !== 1'b1; i++) tick(1);
    check(rom_grant, 1, "grant after");
    check(sclk, 1, "addr bit4 to rom");
    check(sout, 0, "addr bit3 to rom");
    cmd_valid = 1'b1;
    tick(20);
    check(select, 0, "refused under grant");
    check(cmd_ready, 0, "not ready under grant");
    check(rom_data4_in, 1, "return line idle");
    cmd_valid = 1'b0;
    rom_req = 1'b0;
    tick(3);
  endtask
  task automatic t_strap_low();
    do_reset(1'b0);
    check(load_skipped, 1, "skipped");
    check(loads[15:0], 0, "no loads");
    rom_req = 1'b1;
    rom_data1_drive = 1'b1;
    rom_data1_out = 1'b1;
    tick(10);
    check(d1_oe_n, 0, "strap pin driven");
    check(d1_out, 1, "strap pin value");
    rom_data1_drive = 1'b0;
    tick(10);
    check(d1_oe_n, 1, "strap pin released");
    check(rom_data1_in, 0, "strap pin read");
    rom_req = 1'b0;
  endtask
  initial begin
    {rst_n, cmd_valid, cmd_write, rom_req, rom_addr4, rom_addr3} = '0;
    {rom_data1_out, rom_data1_drive} = '0;
    {cmd_addr, cmd_wdata} = '0;
    strap = 1'b1;
    #5;
    t_autoload();
    t_write_read();
    t_rom_share();
    t_strap_low();
    wrap_up();
  end
  // Cuts a hang short well beyond the few thousand cycles the tests need.
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
